// [vme_bridge_consts.svh]
// Purpose: Address map, codes and field positions of the VME bridge.
// Assumes: Short I/O window of 512 bytes, register index is A8..A1.
// Notes:   Definitions only.
`ifndef VME_BRIDGE_CONSTS_SVH
`define VME_BRIDGE_CONSTS_SVH

// ----------------------------------------------------------------
// Address modifiers and base address
// ----------------------------------------------------------------
`define AM_SHORT_SUP   6'h2d
`define AM_SHORT_USR   6'h29
`define BASE_FACTORY   7'h10

// ----------------------------------------------------------------
// Register indices inside the window (A8..A1)
// ----------------------------------------------------------------
`define CFG1_IDX       8'hf8
`define CFG2_IDX       8'hf9
`define RELEASE_IDX    8'h00
`define DMA_WIN_BIT    7

// ----------------------------------------------------------------
// Configuration fields and reset values
// ----------------------------------------------------------------
`define CFG1_RST       8'h00
`define CFG1_LVL_LSB   0
`define CFG1_BR_LSB    3
`define CFG1_ROR_BIT   5
`define CFG2_PRIV_BIT  0
`define CFG2_ADR_LSB   1
`define CFG2_ADR_RST   5'h00

// ----------------------------------------------------------------
// Instrument bus addressing commands
// ----------------------------------------------------------------
`define GP_LISTEN_BASE 7'h20
`define GP_TALK_BASE   7'h40
`define GP_UNLISTEN    7'h3f
`define GP_UNTALK      7'h5f

`endif

// [vme_bridge_pkg.sv]
// Purpose: Types shared by the VME bridge modules.
// Assumes: Active-low VME lines keep their _n polarity in the structs.
// Notes:   Open-collector lines are driven low or released (high).
package vme_bridge_pkg;

	typedef enum logic [2:0] {T_NONE, T_DMA, T_TLC, T_CFG1, T_CFG2}
		target_t;

	typedef struct packed {
		logic        as_n;
		logic        ds0_n;
		logic        ds1_n;
		logic        write_n;
		logic        iack_n;
		logic        iackin_n;
		logic        dtack_n;
		logic        berr_n;
		logic        bbsy_n;
		logic [3:0]  br_n;
		logic [3:0]  bg_in_n;
		logic [5:0]  am;
		logic [23:1] addr;
		logic [15:0] data;
	} vme_in_t;

	typedef struct packed {
		logic        dtack_n;
		logic        sd_oe;
		logic [15:0] sd;
		logic        iackout_n;
		logic [7:1]  irq_n;
		logic [3:0]  br_n;
		logic        bbsy_n;
		logic [3:0]  bg_out_n;
		logic        m_oe;
		logic        as_n;
		logic        ds0_n;
		logic        ds1_n;
		logic        write_n;
		logic [5:0]  am;
		logic [23:1] a;
		logic        md_oe;
		logic [15:0] md;
	} vme_out_t;

	typedef struct packed {
		logic        sel_tlc;
		logic        sel_dma;
		logic [7:0]  addr;
		logic        wr;
		logic [1:0]  be;
		logic [15:0] wdata;
		logic        strobe;
	} chip_out_t;

	typedef struct packed {
		logic [15:0] rdata;
		logic        ack;
		logic        irq;
		logic [7:0]  vector;
	} chip_in_t;

	typedef struct packed {
		logic        req;
		logic [23:1] addr;
		logic        odd;
		logic        word;
		logic        m2m;
		logic        wr;
		logic [5:0]  am;
		logic [15:0] wdata;
	} dma_req_t;

	typedef struct packed {
		logic        done;
		logic        err;
		logic [15:0] rdata;
	} dma_resp_t;

	typedef struct packed {
		logic        cmd_valid;
		logic [6:0]  cmd;
		logic        drive;
		logic [7:0]  data;
		logic        ppoll;
		logic [7:0]  ppoll_resp;
	} gpib_in_t;

	typedef struct packed {
		logic [7:0]  dio_o;
		logic [7:0]  dio_oe;
		logic        talker;
		logic        listener;
	} gpib_out_t;

endpackage : vme_bridge_pkg

// [vme_space_decode.sv]
// Purpose: Short I/O window and address modifier decode.
// Assumes: Inputs are stable while address strobe is low.
// Notes:   Purely combinational; the caller registers the outcome.
`timescale 1ns/1ps
`include "vme_bridge_consts.svh"

module vme_space_decode (
	input  wire logic                    [15:1] addr,
	input  wire logic                    [5:0]  am,
	input  wire logic                           priv_mode,
	input  wire logic                    [6:0]  base,
	output vme_bridge_pkg::target_t             target,
	output logic                         [7:0]  idx
);
	import vme_bridge_pkg::*;

	logic am_ok;

	always_comb begin
		// (R2) supervisor code only
		// (R3) user mode adds 29
		am_ok = (am == `AM_SHORT_SUP) ||
			(!priv_mode && am == `AM_SHORT_USR);
		idx = addr[8:1];
		// (R6) (R21) 512-byte window on A15..A9
		if (!am_ok || addr[15:9] != base) begin
			target = T_NONE;
		end else if (!idx[`DMA_WIN_BIT]) begin
			target = T_DMA;
		end else if (idx == `CFG1_IDX) begin
			target = T_CFG1;
		end else if (idx == `CFG2_IDX) begin
			target = T_CFG2;
		end else begin
			target = T_TLC;
		end
	end

endmodule : vme_space_decode

// [vme_slave_bridge.sv]
// Purpose: VME side of an instrument bus controller board.
// Assumes: All inputs synchronous to core_clk; chip ack is a level.
// Notes:   Slave, interrupter, DMA master and addressing state.
// Behaviour
// (R1) Answer only short I/O (A16) accesses with a matching modifier.
// (R2) Privileged mode accepts modifier 2D only.
// (R3) Non-privileged mode accepts modifiers 29 and 2D.
// (R4) Reset loads access mode from its strap; factory default privileged.
// (R5) Software rewrites access mode via a bit of config register 2.
// (R6) Claim a 512-byte window at the base address.
// (R7) Base bits come from strap block or compare address pins.
// (R8) Factory strap base address is 2000 hex.
// (R9) Chip and config registers use 8-bit odd byte transfers.
// (R10) DMA chip registers take word or even/odd byte transfers.
// (R11) Address-only cycles neither hang the bus nor transfer.
// (R12) Matching interrupt acknowledge returns status/ID on D00-D07.
// (R13) Interrupt request held until a designated register is written.
// (R14) Instrument bus DMA moves single even or odd bytes.
// (R15) Memory-to-memory DMA moves words or even/odd bytes.
// (R16) As master drive a 24-bit address.
// (R17) Software selects release-on-request bus ownership.
// (R18) A talker is unaddressed by its own listen address.
// (R19) A listener is unaddressed by its own talk address.
// (R20) Data lines three-state, open-collector during parallel poll.
// (R21) A15..A09 match the base, A08..A01 select a register.
`timescale 1ns/1ps
`include "vme_bridge_consts.svh"

module vme_slave_bridge (
	input  wire logic                    core_clk,
	input  wire logic                    rst,
	input  vme_bridge_pkg::vme_in_t      vme_i,
	output vme_bridge_pkg::vme_out_t     vme_o,
	input  wire logic                    access_mode_strap,
	input  wire logic [6:0]              base_address_strap_block,
	input  wire logic                    base_from_pins,
	input  wire logic [6:0]              compare_address_bits,
	input  vme_bridge_pkg::chip_in_t     chip_i,
	output vme_bridge_pkg::chip_out_t    chip_o,
	input  vme_bridge_pkg::dma_req_t     dma_i,
	output vme_bridge_pkg::dma_resp_t    dma_o,
	input  vme_bridge_pkg::gpib_in_t     gpib_i,
	output vme_bridge_pkg::gpib_out_t    gpib_o
);
	import vme_bridge_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_ACC, S_ACK, S_WAIT} slave_state_t;
	typedef enum logic [2:0] {M_IDLE, M_ARB, M_ADDR, M_DSTB, M_DATA,
		M_OWN} mast_state_t;

	slave_state_t s_state_r;
	mast_state_t  m_state_r;
	target_t      target;
	logic [7:0]   idx;
	logic [6:0]   base_r;
	logic [7:0]   cfg1_r;
	logic         priv_r;
	logic [4:0]   gp_addr_r;
	logic         irq_r;
	logic [2:0]   irq_lvl;
	logic [1:0]   br_sel;
	logic         ror_en;
	logic         slave_start;
	logic         width_ok;
	logic         iack_mine;
	logic         release_hit;
	logic         any_br;
	logic         byte_word;
	logic [1:0]   ds_pat_r;
	chip_out_t    chip_r;
	dma_resp_t    dma_r;
	logic         talker_r, listener_r;
	logic [7:0]   dio_o_r, dio_oe_r;
	logic         dtack_r;
	logic         sd_oe_r;
	logic [15:0]  sd_r;
	logic         iackout_r;
	logic [7:1]   irq_n_r;
	logic [3:0]   br_r;
	logic         bbsy_r;
	logic [3:0]   bg_out_r;
	logic         m_oe_r;
	logic         m_as_r;
	logic [1:0]   m_ds_r;
	logic         m_wr_n_r;
	logic [5:0]   m_am_r;
	logic [23:1]  m_a_r;
	logic         md_oe_r;
	logic [15:0]  md_r;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// (R1) short I/O decode
	vme_space_decode u_decode (
		.addr      (vme_i.addr[15:1]),
		.am        (vme_i.am),
		.priv_mode (priv_r),
		.base      (base_r),
		.target    (target),
		.idx       (idx)
	);

	assign irq_lvl = cfg1_r[`CFG1_LVL_LSB +: 3];
	assign br_sel  = cfg1_r[`CFG1_BR_LSB +: 2];
	assign ror_en  = cfg1_r[`CFG1_ROR_BIT];
	assign any_br  = ~&vme_i.br_n;

	always_comb begin
		// (R9) odd byte only
		// (R10) DMA chip any width
		width_ok = (target == T_DMA) || (vme_i.ds1_n && !vme_i.ds0_n);
		// (R11) no data strobe, no start
		slave_start = (s_state_r == S_IDLE) && !vme_i.as_n &&
			vme_i.iack_n && target != T_NONE && width_ok &&
			!(vme_i.ds0_n && vme_i.ds1_n) && !m_oe_r;
		// (R12) acknowledge at our level
		iack_mine = (s_state_r == S_IDLE) && !vme_i.as_n &&
			!vme_i.iack_n && !vme_i.iackin_n && !vme_i.ds0_n &&
			irq_r && vme_i.addr[3:1] == irq_lvl && irq_lvl != 3'h0;
		release_hit = slave_start && !vme_i.write_n &&
			target == T_DMA && idx == `RELEASE_IDX;
	end

	// ------------------------------------------------------------
	// Base address and configuration
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		// (R8) factory base while in reset
		if (rst) begin
			base_r <= `BASE_FACTORY;
		// (R7) one source of the two
		end else if (base_from_pins) begin
			base_r <= compare_address_bits;
		end else begin
			base_r <= base_address_strap_block;
		end
	end

	always_ff @(posedge core_clk) begin
		// (R4) strap caught at reset
		if (rst) begin
			cfg1_r    <= `CFG1_RST;
			priv_r    <= access_mode_strap;
			gp_addr_r <= `CFG2_ADR_RST;
		end else if (slave_start && !vme_i.write_n) begin
			if (target == T_CFG1) begin
				cfg1_r <= vme_i.data[7:0];
			end else if (target == T_CFG2) begin
				// (R5) software access mode
				priv_r    <= vme_i.data[`CFG2_PRIV_BIT];
				gp_addr_r <= vme_i.data[`CFG2_ADR_LSB +: 5];
			end
		end
	end

	// ------------------------------------------------------------
	// Slave cycle
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_state_r <= S_IDLE;
			dtack_r   <= 1'b1;
			sd_oe_r   <= 1'b0;
			sd_r      <= 16'h0000;
			iackout_r <= 1'b1;
			chip_r    <= '0;
		end else begin
			case (s_state_r)
			S_IDLE: begin
				if (iack_mine) begin
					// (R12) status/ID on low byte
					sd_r      <= {8'h00, chip_i.vector};
					sd_oe_r   <= 1'b1;
					dtack_r   <= 1'b0;
					s_state_r <= S_ACK;
				end else if (!vme_i.as_n && !vme_i.iack_n &&
					!vme_i.iackin_n) begin
					// Not ours: pass the acknowledge down the chain
					iackout_r <= 1'b0;
					s_state_r <= S_WAIT;
				end else if (slave_start) begin
					if (target == T_CFG1 || target == T_CFG2) begin
						sd_r    <= {8'h00, target == T_CFG1 ? cfg1_r :
							{2'b00, gp_addr_r, priv_r}};
						sd_oe_r <= vme_i.write_n;
						dtack_r <= 1'b0;
						s_state_r <= S_ACK;
					end else begin
						chip_r.sel_tlc <= (target == T_TLC);
						chip_r.sel_dma <= (target == T_DMA);
						chip_r.addr    <= idx;
						chip_r.wr      <= !vme_i.write_n;
						chip_r.be      <= {!vme_i.ds1_n, !vme_i.ds0_n};
						chip_r.wdata   <= vme_i.data;
						chip_r.strobe  <= 1'b1;
						s_state_r      <= S_ACC;
					end
				end
			end
			S_ACC: begin
				if (chip_i.ack) begin
					chip_r.strobe <= 1'b0;
					sd_r          <= chip_i.rdata;
					sd_oe_r       <= !chip_r.wr;
					dtack_r       <= 1'b0;
					s_state_r     <= S_ACK;
				end
			end
			S_ACK: begin
				if (vme_i.ds0_n && vme_i.ds1_n) begin
					dtack_r   <= 1'b1;
					sd_oe_r   <= 1'b0;
					s_state_r <= S_WAIT;
				end
			end
			default: begin
				// Rearm only once the address strobe is gone
				if (vme_i.as_n) begin
					iackout_r <= 1'b1;
					s_state_r <= S_IDLE;
				end
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Interrupter
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_r <= 1'b0;
		// (R13) set wins over release
		end else if (chip_i.irq) begin
			irq_r <= 1'b1;
		end else if (release_hit) begin
			irq_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_n_r <= 7'h7f;
		end else begin
			for (int i = 1; i < 8; i++) begin
				irq_n_r[i] <= !(irq_r && irq_lvl == 3'(i));
			end
		end
	end

	// ------------------------------------------------------------
	// Bus master
	// ------------------------------------------------------------
	// (R14) byte only unless memory-to-memory
	// (R15) word allowed memory-to-memory
	assign byte_word = dma_i.word && dma_i.m2m;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bg_out_r <= 4'hf;
		end else begin
			for (int i = 0; i < 4; i++) begin
				bg_out_r[i] <= vme_i.bg_in_n[i] ||
					(br_sel == 2'(i) && m_state_r == M_ARB);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			m_state_r <= M_IDLE;
			br_r      <= 4'hf;
			bbsy_r    <= 1'b1;
			m_oe_r    <= 1'b0;
			m_as_r    <= 1'b1;
			m_ds_r    <= 2'b11;
			ds_pat_r  <= 2'b11;
			m_wr_n_r  <= 1'b1;
			m_am_r    <= 6'h00;
			m_a_r     <= 23'h000000;
			md_oe_r   <= 1'b0;
			md_r      <= 16'h0000;
			dma_r     <= '0;
		end else begin
			dma_r.done <= 1'b0;
			case (m_state_r)
			M_IDLE: begin
				if (dma_i.req && !dma_r.done) begin
					br_r      <= ~(4'h1 << br_sel);
					m_state_r <= M_ARB;
				end
			end
			M_ARB: begin
				if (!vme_i.bg_in_n[br_sel] && vme_i.bbsy_n &&
					vme_i.as_n) begin
					br_r      <= 4'hf;
					bbsy_r    <= 1'b0;
					m_state_r <= M_ADDR;
				end
			end
			M_ADDR: begin
				// (R16) 24-bit address out
				m_oe_r    <= 1'b1;
				m_a_r     <= dma_i.addr;
				m_am_r    <= dma_i.am;
				m_wr_n_r  <= !dma_i.wr;
				md_r      <= dma_i.wdata;
				md_oe_r   <= dma_i.wr;
				m_as_r    <= 1'b0;
				ds_pat_r  <= {!(byte_word || !dma_i.odd),
					!(byte_word || dma_i.odd)};
				m_state_r <= M_DSTB;
			end
			M_DSTB: begin
				m_ds_r    <= ds_pat_r;
				m_state_r <= M_DATA;
			end
			M_DATA: begin
				if (!vme_i.dtack_n || !vme_i.berr_n) begin
					m_as_r      <= 1'b1;
					m_ds_r      <= 2'b11;
					md_oe_r     <= 1'b0;
					dma_r.done  <= 1'b1;
					dma_r.err   <= !vme_i.berr_n;
					dma_r.rdata <= vme_i.data;
					// (R17) keep the bus only under ROR
					if (ror_en) begin
						m_state_r <= M_OWN;
					end else begin
						bbsy_r    <= 1'b1;
						m_oe_r    <= 1'b0;
						m_state_r <= M_IDLE;
					end
				end
			end
			default: begin
				// (R17) yield to any other request
				if (any_br || !ror_en) begin
					bbsy_r    <= 1'b1;
					m_oe_r    <= 1'b0;
					m_state_r <= M_IDLE;
				end else if (dma_i.req && !dma_r.done &&
					vme_i.dtack_n && vme_i.berr_n) begin
					m_state_r <= M_ADDR;
				end
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Instrument bus addressing and drivers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			talker_r   <= 1'b0;
			listener_r <= 1'b0;
		end else if (gpib_i.cmd_valid) begin
			if (gpib_i.cmd == (`GP_LISTEN_BASE | {2'b00, gp_addr_r})) begin
				// (R18) own listen address
				listener_r <= 1'b1;
				talker_r   <= 1'b0;
			end else if (gpib_i.cmd ==
				(`GP_TALK_BASE | {2'b00, gp_addr_r})) begin
				// (R19) own talk address
				talker_r   <= 1'b1;
				listener_r <= 1'b0;
			end else if (gpib_i.cmd == `GP_UNLISTEN) begin
				listener_r <= 1'b0;
			end else if (gpib_i.cmd[6:5] == 2'b10) begin
				// Untalk or another device's talk address
				talker_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			dio_o_r  <= 8'h00;
			dio_oe_r <= 8'h00;
		// (R20) open-collector in poll
		end else if (gpib_i.ppoll) begin
			dio_o_r  <= 8'h00;
			dio_oe_r <= gpib_i.ppoll_resp;
		end else if (talker_r && gpib_i.drive) begin
			// Lines are negative logic: a one pulls low
			dio_o_r  <= ~gpib_i.data;
			dio_oe_r <= 8'hff;
		end else begin
			dio_o_r  <= 8'h00;
			dio_oe_r <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign vme_o.dtack_n   = dtack_r;
	assign vme_o.sd_oe     = sd_oe_r;
	assign vme_o.sd        = sd_r;
	assign vme_o.iackout_n = iackout_r;
	assign vme_o.irq_n     = irq_n_r;
	assign vme_o.br_n      = br_r;
	assign vme_o.bbsy_n    = bbsy_r;
	assign vme_o.bg_out_n  = bg_out_r;
	assign vme_o.m_oe      = m_oe_r;
	assign vme_o.as_n      = m_as_r;
	assign vme_o.ds0_n     = m_ds_r[0];
	assign vme_o.ds1_n     = m_ds_r[1];
	assign vme_o.write_n   = m_wr_n_r;
	assign vme_o.am        = m_am_r;
	assign vme_o.a         = m_a_r;
	assign vme_o.md_oe     = md_oe_r;
	assign vme_o.md        = md_r;
	assign chip_o          = chip_r;
	assign dma_o           = dma_r;
	assign gpib_o          = {dio_o_r, dio_oe_r, talker_r, listener_r};

endmodule : vme_slave_bridge

// [vme_slave_bridge_assertions.sv]
// Purpose: Port-level checks of the VME bridge.
// Assumes: The bench holds dma_i steady while a transfer runs.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ps

module vme_slave_bridge_assertions (
	input wire logic                core_clk,
	input wire logic                rst,
	input vme_bridge_pkg::vme_in_t  vme_i,
	input vme_bridge_pkg::vme_out_t vme_o,
	input wire logic [6:0]          base_address_strap_block,
	input wire logic                base_from_pins,
	input wire logic [6:0]          compare_address_bits,
	input vme_bridge_pkg::chip_in_t chip_i,
	input vme_bridge_pkg::chip_out_t chip_o,
	input vme_bridge_pkg::dma_req_t dma_i,
	input vme_bridge_pkg::dma_resp_t dma_o,
	input vme_bridge_pkg::gpib_in_t gpib_i,
	input vme_bridge_pkg::gpib_out_t gpib_o
);
	import vme_bridge_pkg::*;

	logic [6:0] base;
	assign base = base_from_pins ? compare_address_bits
		: base_address_strap_block;

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// --------
	// Port checks
	// --------
	a_bad_am_refused: assert property (
		$fell(vme_i.as_n) && vme_i.iack_n
		&& !(vme_i.am inside {6'h2d, 6'h29}) |-> vme_o.dtack_n [*4])
		else $error("strange modifier answered");
	a_window_miss: assert property (
		$fell(vme_i.as_n) && vme_i.iack_n && vme_i.addr[15:9] != base
		|-> vme_o.dtack_n [*4])
		else $error("address outside window answered");
	a_addr_only: assert property (
		(!vme_i.as_n && vme_i.ds0_n && vme_i.ds1_n) [*3] |-> vme_o.dtack_n)
		else $error("acknowledge without data strobe");
	a_tlc_odd_byte: assert property (
		chip_o.strobe && chip_o.sel_tlc |-> chip_o.be == 2'b01)
		else $error("chip access not on odd byte");
	a_iack_status_id: assert property (
		!vme_i.iack_n && !vme_o.dtack_n && vme_o.sd_oe
		|-> vme_o.sd == {8'h00, chip_i.vector})
		else $error("wrong status byte");
	a_irq_held: assert property (
		vme_i.as_n && vme_o.irq_n != 7'h7f |=> $stable(vme_o.irq_n))
		else $error("request dropped without access");

	a_dma_byte_lane: assert property (
		vme_o.m_oe && !(vme_o.ds0_n && vme_o.ds1_n)
		&& !(dma_i.word && dma_i.m2m)
		|-> vme_o.ds0_n == !dma_i.odd && vme_o.ds1_n == dma_i.odd)
		else $error("byte lane wrong");
	a_dma_word_lane: assert property (
		vme_o.m_oe && !(vme_o.ds0_n && vme_o.ds1_n) && dma_i.word
		&& dma_i.m2m |-> !vme_o.ds0_n && !vme_o.ds1_n)
		else $error("word transfer not on both lanes");
	a_master_addr: assert property (
		vme_o.m_oe && !vme_o.as_n
		|-> vme_o.a == dma_i.addr && vme_o.am == dma_i.am)
		else $error("master address wrong");
	a_role_exclusive: assert property (
		!(gpib_o.talker && gpib_o.listener))
		else $error("talker and listener together");
	a_ppoll_drive: assert property (
		gpib_i.ppoll |=> gpib_o.dio_o == 8'h00
		&& gpib_o.dio_oe == $past(gpib_i.ppoll_resp))
		else $error("poll drive wrong");

	c_iack: cover property (!vme_o.dtack_n && !vme_i.iack_n);
	c_done: cover property (dma_o.done);
	c_ror_hold: cover property (!vme_o.bbsy_n && vme_o.as_n && vme_o.m_oe);
endmodule : vme_slave_bridge_assertions

// [vme_backplane_model.sv]
// Purpose: Arbiter and memory on the backplane for the bridge.
// Assumes: One requester line at a time is granted.
// Notes:   Released data lines change every cycle to expose late sampling.
`timescale 1ns/1ps

module vme_backplane_model (
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  vme_bridge_pkg::vme_out_t vme_o,
	input  wire logic                slow,
	output logic [3:0]               bg_in_n,
	output logic                     dtack_n,
	output logic [15:0]              data
);
	import vme_bridge_pkg::*;

	localparam logic [15:0] MEM_WORD = 16'hc3a5;
	logic [2:0] wait_r;
	logic       strobed;

	assign strobed = vme_o.m_oe && !(vme_o.ds0_n && vme_o.ds1_n);

	// Grant only while nobody holds the bus
	always_ff @(posedge core_clk) begin
		if (rst) begin
			bg_in_n <= 4'hf;
		end else begin
			bg_in_n <= vme_o.bbsy_n ? vme_o.br_n : 4'hf;
		end
	end

	// Slow mode stretches the strobe-to-acknowledge time
	always_ff @(posedge core_clk) begin
		if (rst || !strobed) begin
			wait_r  <= 3'h0;
			dtack_n <= 1'b1;
		end else if (wait_r == (slow ? 3'h4 : 3'h0)) begin
			dtack_n <= 1'b0;
		end else begin
			wait_r <= wait_r + 3'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			data <= 16'h0000;
		end else begin
			data <= (strobed && vme_o.write_n) ? MEM_WORD : ~data;
		end
	end
endmodule : vme_backplane_model

// [tb.sv]
// Purpose: Self-checking bench of the VME bridge.
// Assumes: The bench plays the CPU; the model answers master cycles.
// Notes:   Plain slave cases sit in a table; the rest follow it.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, b); end end

module tb;
	import vme_bridge_pkg::*;

	typedef struct {
		logic [15:0] ad;
		logic [5:0]  am;
		logic [1:0]  ds;
		logic        wr;
		logic [7:0]  wd;
		logic        ack;
	} row_t;

	logic        core_clk = 1'b0;
	logic        rst      = 1'b1;
	logic        strap    = 1'b1;
	logic        pins     = 1'b0;
	logic        slow     = 1'b0;
	vme_in_t     vin;
	vme_in_t     vme_i;
	vme_out_t    vme_o;
	chip_in_t    chip_i;
	chip_out_t   chip_o;
	dma_req_t    dma_i;
	dma_resp_t   dma_o;
	gpib_in_t    gpib_i;
	gpib_out_t   gpib_o;
	logic [3:0]  mdl_bg;
	logic        mdl_dtack;
	logic [15:0] mdl_data;
	logic        ack;
	logic [15:0] rd;
	int          failures = 0;
	int          n_tests  = 0;
	// Read rows expect wd back
	row_t rows [15] = '{
		'{16'h21f1, 6'h2d, 2'b01, 1'b1, 8'h0d, 1'b1},
		'{16'h21f1, 6'h2d, 2'b01, 1'b0, 8'h0d, 1'b1},
		'{16'h21f1, 6'h29, 2'b01, 1'b0, 8'h00, 1'b0},
		'{16'h21f1, 6'h3d, 2'b01, 1'b0, 8'h00, 1'b0},
		'{16'h21f0, 6'h2d, 2'b10, 1'b1, 8'h00, 1'b0},
		'{16'h21ff, 6'h2d, 2'b01, 1'b1, 8'h11, 1'b1},
		'{16'h20fe, 6'h2d, 2'b10, 1'b1, 8'h22, 1'b1},
		'{16'h2000, 6'h2d, 2'b11, 1'b1, 8'h33, 1'b1},
		'{16'h2201, 6'h2d, 2'b01, 1'b1, 8'h00, 1'b0},
		'{16'h1ff1, 6'h2d, 2'b01, 1'b0, 8'h00, 1'b0},
		'{16'h21f3, 6'h2d, 2'b01, 1'b1, 8'h06, 1'b1},
		'{16'h21f1, 6'h29, 2'b01, 1'b0, 8'h0d, 1'b1},
		'{16'h21f3, 6'h29, 2'b01, 1'b0, 8'h06, 1'b1},
		'{16'h21f3, 6'h2d, 2'b01, 1'b1, 8'h07, 1'b1},
		'{16'h21f1, 6'h29, 2'b01, 1'b0, 8'h00, 1'b0}};
	// Command, then expected talker and listener
	logic [8:0] cmds [7] = '{{7'h43, 2'b10}, {7'h23, 2'b01}, {7'h43, 2'b10},
		{7'h5f, 2'b00}, {7'h23, 2'b01}, {7'h3f, 2'b00}, {7'h43, 2'b10}};
	// Odd, word, memory-to-memory, write
	logic [3:0] modes [5] = '{4'b1000, 4'b0001, 4'b0100, 4'b0110, 4'b1010};

	always #12.5 core_clk = ~core_clk;
	always @(negedge core_clk) chip_i.ack <= chip_o.strobe;
	always_comb begin
		vme_i = vin;
		vme_i.bg_in_n = mdl_bg;
		vme_i.dtack_n = mdl_dtack;
		if (vme_o.m_oe) vme_i.data = mdl_data;
	end

	vme_slave_bridge i_dut (.core_clk(core_clk), .rst(rst), .vme_i(vme_i),
		.vme_o(vme_o), .access_mode_strap(strap),
		.base_address_strap_block(7'h10), .base_from_pins(pins),
		.compare_address_bits(7'h35), .chip_i(chip_i), .chip_o(chip_o),
		.dma_i(dma_i), .dma_o(dma_o), .gpib_i(gpib_i), .gpib_o(gpib_o));
	vme_backplane_model i_bus (.core_clk(core_clk), .rst(rst), .vme_o(vme_o),
		.slow(slow), .bg_in_n(mdl_bg), .dtack_n(mdl_dtack), .data(mdl_data));

	// --------
	// Bus tasks
	// --------
	task vcyc(input logic [15:0] ad, input logic [5:0] am, input logic wr,
		input logic [1:0] ds, input logic [7:0] wd, input logic iack);
		int k;
		@(negedge core_clk);
		vin = {1'b0, !ds[0], !ds[1], !wr, !iack, !iack, 11'h7ff, am,
			{8'h00, ad[15:1]}, {wd, wd}};
		ack = 1'b0;
		for (k = 0; k < 12 && !ack; k++) begin
			@(negedge core_clk);
			ack = (vme_o.dtack_n === 1'b0);
		end
		rd = vme_o.sd;
		{vin.ds0_n, vin.ds1_n} = 2'b11;
		for (k = 0; k < 8 && vme_o.dtack_n !== 1'b1; k++) @(negedge core_clk);
		vin = {17'h1ffff, vin[44:0]};
	endtask : vcyc

	task dma(input logic [3:0] m);
		int k;
		@(negedge core_clk);
		dma_i = {1'b1, 23'h2abcde, m, 6'h3d, 16'h1234};
		for (k = 0; k < 80 && dma_o.done !== 1'b1; k++) @(negedge core_clk);
		`CHK({dma_o.done, dma_o.err}, 2'b10)
		if (m == 4'b0110) `CHK(dma_o.rdata, 16'hc3a5)
		dma_i.req = 1'b0;
	endtask : dma

	task results();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	initial begin
		repeat (30000) @(posedge core_clk);
		failures++;
		results();
	end

	initial begin
		vin = {17'h1ffff, 6'h00, 23'h0, 16'h0000};
		chip_i = {16'h5aa5, 1'b0, 1'b0, 8'h9c};
		dma_i = '0;
		gpib_i = '0;
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK({vme_o.irq_n, vme_o.dtack_n, vme_o.m_oe}, 9'h1fe)
		foreach (rows[i]) begin
			vcyc(rows[i].ad, rows[i].am, rows[i].wr, rows[i].ds, rows[i].wd, 0);
			`CHK(ack, rows[i].ack)
			if (ack && !rows[i].wr) `CHK(rd[7:0], rows[i].wd)
		end
		`CHK(chip_o, 30'h100e6666)
		$display("test table done");
		pins = 1'b1;
		vcyc(16'h6bf1, 6'h2d, 1'b0, 2'b01, 8'h00, 1'b0);
		`CHK(ack, 1'b1)
		vcyc(16'h21f1, 6'h2d, 1'b0, 2'b01, 8'h00, 1'b0);
		`CHK(ack, 1'b0)
		pins = 1'b0;
		$display("test base source done");
		@(negedge core_clk);
		vin = {1'b0, 16'hffff, 6'h2d, 23'h0010f8, 16'h0000};
		repeat (6) @(negedge core_clk);
		`CHK(vme_o.dtack_n, 1'b1)
		vin.as_n = 1'b1;
		vcyc(16'h21f1, 6'h2d, 1'b0, 2'b01, 8'h00, 1'b0);
		`CHK(ack, 1'b1)
		$display("test address only done");
		vcyc(16'h000a, 6'h2d, 1'b0, 2'b01, 8'h00, 1'b1);
		`CHK({ack, vme_o.iackout_n}, 2'b00)
		chip_i.irq = 1'b1;
		@(negedge core_clk);
		chip_i.irq = 1'b0;
		@(negedge core_clk);
		`CHK(vme_o.irq_n, 7'h6f)
		vcyc(16'h000a, 6'h2d, 1'b0, 2'b01, 8'h00, 1'b1);
		`CHK({ack, rd}, 17'h1009c)
		vcyc(16'h2101, 6'h2d, 1'b1, 2'b01, 8'h00, 1'b0);
		`CHK(vme_o.irq_n, 7'h6f)
		vcyc(16'h2001, 6'h2d, 1'b1, 2'b01, 8'h00, 1'b0);
		`CHK(vme_o.irq_n, 7'h7f)
		$display("test interrupt done");
		foreach (modes[i]) begin
			slow = i[0];
			dma(modes[i]);
			repeat (3) @(negedge core_clk);
			`CHK(vme_o.bbsy_n, 1'b1)
		end
		vcyc(16'h21f1, 6'h2d, 1'b1, 2'b01, 8'h2d, 1'b0);
		dma(4'b1000);
		repeat (3) @(negedge core_clk);
		`CHK(vme_o.bbsy_n, 1'b0)
		vin.br_n = 4'he;
		repeat (3) @(negedge core_clk);
		`CHK({vme_o.bbsy_n, vme_o.m_oe}, 2'b10)
		vin.br_n = 4'hf;
		$display("test master done");
		foreach (cmds[i]) begin
			@(negedge core_clk);
			gpib_i.cmd_valid = 1'b1;
			gpib_i.cmd = cmds[i][8:2];
			@(negedge core_clk);
			gpib_i.cmd_valid = 1'b0;
			`CHK({gpib_o.talker, gpib_o.listener}, cmds[i][1:0])
		end
		gpib_i.drive = 1'b1;
		gpib_i.data = 8'h3c;
		repeat (2) @(negedge core_clk);
		`CHK({gpib_o.dio_oe, gpib_o.dio_o}, 16'hffc3)
		gpib_i.ppoll = 1'b1;
		gpib_i.ppoll_resp = 8'h81;
		repeat (2) @(negedge core_clk);
		`CHK({gpib_o.dio_oe, gpib_o.dio_o}, 16'h8100)
		gpib_i.ppoll = 1'b0;
		$display("test instrument bus done");
		strap = 1'b0;
		rst = 1'b1;
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		repeat (2) @(negedge core_clk);
		vcyc(16'h21f1, 6'h29, 1'b0, 2'b01, 8'h00, 1'b0);
		`CHK(ack, 1'b1)
		$display("test strap reset done");
		results();
	end
endmodule : tb

bind vme_slave_bridge vme_slave_bridge_assertions i_chk (
	.core_clk(core_clk), .rst(rst), .vme_i(vme_i), .vme_o(vme_o),
	.base_address_strap_block(base_address_strap_block),
	.base_from_pins(base_from_pins),
	.compare_address_bits(compare_address_bits), .chip_i(chip_i),
	.chip_o(chip_o), .dma_i(dma_i), .dma_o(dma_o), .gpib_i(gpib_i),
	.gpib_o(gpib_o));
